// >>> logic/sector_password_protection.sv
// per-sector access control against rf and i2c requests
`timescale 1ns/1ns
`include "sector_guard_defs.svh"
module sector_password_protection
	import sector_guard_pkg::*;
(
	// clock and reset
	input  wire logic     MCLK,
	input  wire logic     RST_N,
	// rf command side
	input  wire rf_req_s  RF_REQ,
	output      rf_rsp_s  RF_RSP,
	// i2c guard area side
	input  wire i2c_req_s I2C_REQ,
	output      i2c_rsp_s I2C_RSP
);

	////////////////////////////////////////////////////////////////
	// helpers

	// true when the sector's linked key is currently in force
	function automatic logic key_held(
		input guard_t     g,
		input logic [1:0] shown,
		input logic       revoked
	);
		logic [1:0] link;
		link = g[`GB_KEY_HI:`GB_KEY_LO];
		// key field 00 never counts as presented
		key_held = (link != `KEY_NONE) && (link == shown) && !revoked;
	endfunction

	// decides one rf access from the guard byte
	function automatic logic may_access(
		input guard_t g,
		input logic   held,
		input logic   wr
	);
		logic [1:0] pol;
		pol = g[`GB_POL_HI:`GB_POL_LO];
		may_access = 1'b0;
		if (!g[`GB_LOCK]) begin
			// unlocked sector: open both ways
			may_access = 1'b1;
		end else begin
			case (pol)
				// reads open, writes keyed
				`POL_WR_KEY: may_access = wr ? held : 1'b1;
				// fully open while locked
				`POL_OPEN:   may_access = 1'b1;
				// keyed both ways
				`POL_RW_KEY: may_access = held;
				// keyed read, never a write
				`POL_RD_KEY: may_access = wr ? 1'b0 : held;
				default:     may_access = 1'b0;
			endcase
		end
	endfunction

	// maps a key select code to its store slot
	function automatic logic [1:0] key_slot(
		input logic [1:0] sel
	);
		// codes 1..3 are slots 0..2
		key_slot = 2'(sel - `OFS_KEY_ONE);
	endfunction

	////////////////////////////////////////////////////////////////
	// state

	core_s core_ff;     // every flop of the block
	core_s nxt_core;    // its next value

	// rf request decode
	guard_t     rf_g;       // guard byte of the addressed sector
	logic       rf_held;    // linked key is in force
	logic       rf_ok;      // read or write allowed
	logic [1:0] rf_slot;    // key store slot named
	logic       sel_valid;  // key select is 1..3

	// i2c request decode
	logic       i2c_hit;    // request aimed at the guard area

	////////////////////////////////////////////////////////////////
	// request decode

	always_comb begin
		rf_g = core_ff.guard[RF_REQ.sector];
		rf_held = key_held(rf_g, core_ff.shown,
			core_ff.revoked[RF_REQ.sector]);
		// write ops ask for write rights, all others read
		rf_ok = may_access(rf_g, rf_held,
			RF_REQ.op == RF_OP_WRITE);
		rf_slot = key_slot(RF_REQ.key_sel);
		sel_valid = RF_REQ.key_sel != `KEY_NONE;
		// the master must raise the upper chip-select bit
		i2c_hit = I2C_REQ.valid && I2C_REQ.upper_cs;
	end

	////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		nxt_core = core_ff;
		// answers are one-cycle pulses
		nxt_core.rf_rsp = '0;
		nxt_core.i2c_rsp = '0;

		// rf command handling
		if (RF_REQ.valid) begin
			nxt_core.rf_rsp.valid = 1'b1;
			case (RF_REQ.op)
				RF_OP_READ: begin
					if (rf_ok) begin
						nxt_core.rf_rsp.grant = 1'b1;
						// guard byte rides along on option reads
						if (RF_REQ.option) begin
							nxt_core.rf_rsp.guard = rf_g;
						end
					end else begin
						// denied read: error, memory untouched
						nxt_core.rf_rsp.err = 1'b1;
					end
				end
				RF_OP_WRITE: begin
					if (rf_ok) begin
						nxt_core.rf_rsp.grant = 1'b1;
					end else begin
						// denied write: error, memory untouched
						nxt_core.rf_rsp.err = 1'b1;
					end
				end
				RF_OP_LOCK: begin
					if (rf_g[`GB_LOCK]) begin
						// a locked sector keeps its settings
						nxt_core.rf_rsp.err = 1'b1;
					end else begin
						// bits 4:1 from the command, lock forced
						nxt_core.guard[RF_REQ.sector]
							[`GB_KEY_HI:`GB_LOCK_LO] = RF_REQ.lock_bits;
						nxt_core.guard[RF_REQ.sector][`GB_LOCK] = 1'b1;
						nxt_core.rf_rsp.grant = 1'b1;
					end
				end
				RF_OP_SHOW: begin
					if (sel_valid
						&& RF_REQ.data == core_ff.key[rf_slot]) begin
						// good key: rights hold until next show
						nxt_core.shown = RF_REQ.key_sel;
						nxt_core.revoked = '0;
						nxt_core.rf_rsp.grant = 1'b1;
					end else begin
						// bad key drops every granted right
						nxt_core.shown = `KEY_NONE;
						nxt_core.rf_rsp.err = 1'b1;
					end
				end
				RF_OP_SETKEY: begin
					// only the key in force may be replaced
					if (sel_valid
						&& core_ff.shown == RF_REQ.key_sel) begin
						// new value is live from the next cycle
						nxt_core.key[rf_slot] = RF_REQ.data;
						nxt_core.rf_rsp.grant = 1'b1;
					end else begin
						nxt_core.rf_rsp.err = 1'b1;
					end
				end
				default: begin
					// unknown opcode is refused
					nxt_core.rf_rsp.err = 1'b1;
				end
			endcase
		end

		// i2c guard area handling; runs after rf so that an i2c
		// write in the same cycle as an rf lock has the last word
		if (i2c_hit) begin
			nxt_core.i2c_rsp.valid = 1'b1;
			if (!I2C_REQ.write) begin
				// reads need no key; byte n is sector n
				nxt_core.i2c_rsp.rdata =
					nxt_core.guard[I2C_REQ.addr];
			end else if (I2C_REQ.key_ok) begin
				// stored with bits 7:5 forced to zero
				nxt_core.guard[I2C_REQ.addr] =
					I2C_REQ.wdata & `GB_USED_MASK;
				// sector drops its rf rights at once
				nxt_core.revoked[I2C_REQ.addr] = 1'b1;
			end else begin
				// write without the i2c key is refused
				nxt_core.i2c_rsp.err = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// register stage

	// all state in one register; outputs come straight from it
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			// guard bytes start cleared: all open
			core_ff.guard <= {`SECTOR_COUNT{`GB_RESET}};
			// keys start at zero and are active
			core_ff.key <= {`KEY_COUNT{`KEY_RESET}};
			// nothing presented after power-up
			core_ff.shown <= `KEY_NONE;
			core_ff.revoked <= '0;
			core_ff.rf_rsp <= '0;
			core_ff.i2c_rsp <= '0;
		end else begin
			core_ff <= nxt_core;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs

	// the guard bytes live in words at 0,4,8,12 (lane n mod 4);
	// the key store is not readable from either side by design
	assign RF_RSP = core_ff.rf_rsp;
	assign I2C_RSP = core_ff.i2c_rsp;

endmodule

// >>> logic/sector_guard_defs.svh
// constants for the sector password protection block
// Contract
// - guard byte: lock, policy, key link, zeros
// - four guard bytes per word, lane n mod 4
// - option-flag reads return the guard byte
// - guard bytes reset to zero
// - unlocked open; policy 00 and 01 (the code keys writes under policy 00, reads stay open)
// - policy 10 keyed access; 11 keyed read only
// - key field 00 none, else key 1..3
// - three 32-bit keys at system addresses 1..3
// - key write activates new value when done
// - key rewrite needs that key presented first
// - all keys reset to zero and active
// - lock writes bits 4:1, forces lock bit
// - locked sector refuses lock with error
// - good key grants rights until next presentation
// - bad key revokes all granted rights
// - i2c reads of guard area always allowed
// - i2c guard writes need i2c key shown
// - i2c guard write resets sector rf rights
`ifndef SECTOR_GUARD_DEFS_SVH
`define SECTOR_GUARD_DEFS_SVH
// geometry
`define SECTOR_COUNT    16
`define KEY_COUNT       3
// guard byte fields
`define GB_LOCK         0
`define GB_POL_HI       2
`define GB_POL_LO       1
`define GB_KEY_HI       4
`define GB_KEY_LO       3
`define GB_LOCK_LO      1
`define GB_USED_MASK    8'h1F
`define GB_RESET        8'h00
// policy and key link codes
`define POL_WR_KEY      2'h0
`define POL_OPEN        2'h1
`define POL_RW_KEY      2'h2
`define POL_RD_KEY      2'h3
`define KEY_NONE        2'h0
`define KEY_RESET       32'h0000_0000
// guard words, i2c byte addresses
`define OFS_GUARD_WORD_0 4'h0
`define OFS_GUARD_WORD_1 4'h4
`define OFS_GUARD_WORD_2 4'h8
`define OFS_GUARD_WORD_3 4'hC
// keys, system block addresses
`define OFS_KEY_ONE     2'h1
`define OFS_KEY_TWO     2'h2
`define OFS_KEY_THREE   2'h3
`endif

// >>> logic/sector_guard_pkg.sv
// types shared by the sector password protection block
`include "sector_guard_defs.svh"
package sector_guard_pkg;
	typedef enum logic [2:0] {
		RF_OP_READ   = 3'b000,
		RF_OP_WRITE  = 3'b001,
		RF_OP_LOCK   = 3'b010,
		RF_OP_SHOW   = 3'b011,
		RF_OP_SETKEY = 3'b100
	} rf_op_e;
	typedef logic [7:0] guard_t;
	typedef struct packed {
		logic       valid;
		rf_op_e     op;
		logic [3:0] sector;
		logic [1:0] key_sel;
		logic       option;
		logic [31:0] data;
		logic [3:0] lock_bits;
	} rf_req_s;
	typedef struct packed {
		logic   valid;
		logic   grant;
		logic   err;
		guard_t guard;
	} rf_rsp_s;
	typedef struct packed {
		logic       valid;
		logic       write;
		logic       upper_cs;
		logic [3:0] addr;
		guard_t     wdata;
		logic       key_ok;
	} i2c_req_s;
	typedef struct packed {
		logic   valid;
		logic   err;
		guard_t rdata;
	} i2c_rsp_s;
	typedef struct packed {
		guard_t [`SECTOR_COUNT-1:0]     guard;
		logic [`KEY_COUNT-1:0][31:0]    key;
		logic [1:0]                     shown;
		logic [`SECTOR_COUNT-1:0]       revoked;
		rf_rsp_s                        rf_rsp;
		i2c_rsp_s                       i2c_rsp;
	} core_s;
endpackage

// >>> verification/sector_guard_props.sv
// port checker for the sector guard block
`timescale 1ns/1ns
module sector_guard_props
	import sector_guard_pkg::*;
(
	// clock and reset
	input wire logic     MCLK,
	input wire logic     RST_N,
	// watched traffic
	input wire rf_req_s  RF_REQ,
	input wire rf_rsp_s  RF_RSP,
	input wire i2c_req_s I2C_REQ,
	input wire i2c_rsp_s I2C_RSP
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	//////////////////////////////////////////
	// a request aimed at the guard area
	sequence s_i2c; I2C_REQ.valid && I2C_REQ.upper_cs; endsequence
	// presenting key select 00 can never match
	sequence s_bad;
		RF_REQ.valid && RF_REQ.op == RF_OP_SHOW && RF_REQ.key_sel == 2'h0;
	endsequence
	property p_rf_ans; RF_REQ.valid |=> RF_RSP.valid && RF_RSP.grant != RF_RSP.err; endproperty
	a_rf_ans: assert property (p_rf_ans) else $error("rf answer missing");
	property p_rf_idle; !RF_REQ.valid |=> !RF_RSP.valid; endproperty
	a_rf_idle: assert property (p_rf_idle) else $error("rf answer unasked");
	property p_guard_hi; RF_RSP.valid |-> RF_RSP.guard[7:5] == 3'h0; endproperty
	a_guard_hi: assert property (p_guard_hi) else $error("guard top bits set");
	property p_bad_show; s_bad |=> RF_RSP.err; endproperty
	a_bad_show: assert property (p_bad_show) else $error("bad key taken");
	property p_i2c_ans; s_i2c |=> I2C_RSP.valid; endproperty
	a_i2c_ans: assert property (p_i2c_ans) else $error("i2c answer missing");
	property p_i2c_cs; !(I2C_REQ.valid && I2C_REQ.upper_cs) |=> !I2C_RSP.valid; endproperty
	a_i2c_cs: assert property (p_i2c_cs) else $error("i2c answer unasked");
	property p_i2c_key; s_i2c ##0 (I2C_REQ.write && !I2C_REQ.key_ok) |=> I2C_RSP.err; endproperty
	a_i2c_key: assert property (p_i2c_key) else $error("keyless write taken");
	property p_i2c_rd; s_i2c ##0 !I2C_REQ.write |=> !I2C_RSP.err && I2C_RSP.rdata[7:5] == 3'h0;
	endproperty
	a_i2c_rd: assert property (p_i2c_rd) else $error("i2c read refused");
endmodule
bind sector_password_protection sector_guard_props i_props (.MCLK(MCLK), .RST_N(RST_N),
	.RF_REQ(RF_REQ), .RF_RSP(RF_RSP), .I2C_REQ(I2C_REQ), .I2C_RSP(I2C_RSP));

// >>> verification/sector_guard_peer.sv
// reader and i2c master model
`timescale 1ns/1ns
module sector_guard_peer
	import sector_guard_pkg::*;
(
	// clock
	input wire logic mclk,
	// requests to the block
	output rf_req_s  rf_req,
	output i2c_req_s i2c_req
);
	initial begin
		rf_req = '0;
		i2c_req = '0;
	end
	// held one cycle; released lines show the inverse so stale values never look valid
	task automatic rf(rf_op_e op, logic [3:0] s, logic [1:0] ks, logic o, logic [31:0] d,
		logic [3:0] lb);
		@(negedge mclk);
		rf_req = {1'b1, op, s, ks, o, d, lb};
		@(negedge mclk);
		rf_req = ~rf_req;
	endtask
	task automatic i2c(logic wr, logic cs, logic [3:0] a, logic [7:0] wd, logic ko);
		@(negedge mclk);
		i2c_req = {1'b1, wr, cs, a, wd, ko};
		@(negedge mclk);
		i2c_req = ~i2c_req;
	endtask
endmodule

// >>> verification/tb.sv
// self-checking bench for the sector guard block
`timescale 1ns/1ns
module tb;
	import sector_guard_pkg::*;
	logic        mclk;
	logic        rst_n;
	rf_req_s     rf_req;
	rf_rsp_s     rf_rsp;
	i2c_req_s    i2c_req;
	i2c_rsp_s    i2c_rsp;
	logic [9:0]  rq_q[$];
	logic [9:0]  iq_q[$];
	logic [9:0]  nx;
	logic [31:0] k;
	logic [31:0] seed = 32'h0000_9653;
	int          failures;
	int          comparisons;
	int          cyc;
	sector_password_protection i_dut (.MCLK(mclk), .RST_N(rst_n), .RF_REQ(rf_req),
		.RF_RSP(rf_rsp), .I2C_REQ(i2c_req), .I2C_RSP(i2c_rsp));
	sector_guard_peer i_peer (.mclk(mclk), .rf_req(rf_req), .i2c_req(i2c_req));
	//////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(string n, logic [9:0] s, logic [9:0] e);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("ERROR %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// rf command with expected grant and guard byte; option always set
	task automatic rq(rf_op_e op, logic [3:0] s, logic [1:0] ks, logic [31:0] d, logic [3:0] lb,
		logic g, logic [7:0] gd);
		rq_q.push_back({g, !g, gd});
		i_peer.rf(op, s, ks, 1'b1, d, lb);
	endtask
	// guard area access; write answers carry no data worth comparing
	task automatic iq(logic wr, logic [3:0] a, logic [7:0] wd, logic ko, logic e, logic [7:0] rd);
		iq_q.push_back({wr, e, rd});
		i_peer.i2c(wr, 1'b1, a, wd, ko);
	endtask
	//////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// hang guard, far above the under one hundred cycles needed
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 2000) begin
			failures++;
			close_out();
		end
	end
	// answers stand one cycle; sampled mid-cycle against the oldest note
	always @(negedge mclk) begin
		if (rf_rsp.valid === 1'b1) begin
			nx = rq_q.size() > 0 ? rq_q.pop_front() : 10'h3FF;
			chk("rf", rf_rsp[9:0], nx);
		end
		if (i2c_rsp.valid === 1'b1) begin
			nx = iq_q.size() > 0 ? iq_q.pop_front() : 10'h3FF;
			chk("i2c", {nx[9], i2c_rsp.err, nx[9] ? 8'h00 : i2c_rsp.rdata}, nx);
		end
	end
	initial begin
		rst_n = 1'b0;
		repeat (6) @(negedge mclk);
		rst_n = 1'b1;
		rq(RF_OP_READ, 4'h0, 2'h0, '0, 4'h0, 1'b1, 8'h00);
		iq(1'b0, 4'h0, 8'h00, 1'b0, 1'b0, 8'h00);
		rq(RF_OP_SHOW, 4'h0, 2'h1, '0, 4'h0, 1'b1, 8'h00);
		for (int p = 0; p < 4; p++) begin
			rq(RF_OP_LOCK, 4'(p + 1), 2'h1, '0, {2'h1, 2'(p)},
				1'b1, 8'h00);
		end
		rq(RF_OP_LOCK, 4'h1, 2'h1, '0, 4'h0, 1'b0, 8'h00);
		rq(RF_OP_SHOW, 4'h0, 2'h2, 32'h0000_0001, 4'h0, 1'b0, 8'h00);
		// first pass with no key held, second with key one held
		for (int h = 0; h < 2; h++) begin
			for (int p = 0; p < 4; p++) begin
				rq(RF_OP_READ, 4'(p + 1), 2'h0, '0, 4'h0, h > 0 || p < 2,
					(h > 0 || p < 2) ? 8'(9 + 2 * p) : 8'h00);
				rq(RF_OP_WRITE, 4'(p + 1), 2'h0, '0, 4'h0, h > 0 ? p != 3 : p == 1, 8'h00);
			end
			rq(RF_OP_SHOW, 4'h0, 2'h1, '0, 4'h0, 1'b1, 8'h00);
		end
		k = xs();
		rq(RF_OP_SETKEY, 4'h0, 2'h2, k, 4'h0, 1'b0, 8'h00);
		rq(RF_OP_SETKEY, 4'h0, 2'h1, k, 4'h0, 1'b1, 8'h00);
		rq(RF_OP_SHOW, 4'h0, 2'h1, '0, 4'h0, 1'b0, 8'h00);
		rq(RF_OP_SHOW, 4'h0, 2'h1, k, 4'h0, 1'b1, 8'h00);
		iq(1'b1, 4'h3, 8'h0D, 1'b0, 1'b1, 8'h00);
		iq(1'b1, 4'h3, 8'h0D, 1'b1, 1'b0, 8'h00);
		rq(RF_OP_READ, 4'h3, 2'h0, '0, 4'h0, 1'b0, 8'h00);
		k = xs();
		iq(1'b1, 4'h6, k[7:0], 1'b1, 1'b0, 8'h00);
		iq(1'b0, 4'h6, 8'h00, 1'b0, 1'b0, k[7:0] & 8'h1F);
		i_peer.i2c(1'b0, 1'b0, 4'h6, 8'h00, 1'b0);
		repeat (3) @(negedge mclk);
		chk("left", 10'(rq_q.size() + iq_q.size()), 10'h000);
		close_out();
	end
endmodule
